//--- sfc_pkg.sv
// shared constants and types for the serial clock and fifo section
package sfc_pkg;

    // ==========================================================
    // clocking
    // ==========================================================
    localparam int unsigned CORE_CLK_HZ = 50_000_000;
    localparam int unsigned CORE_CLK_NS = 20;

    // ==========================================================
    // widths and depths
    // ==========================================================
    localparam int unsigned WORD_W     = 32;   // one frame per entry
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned LVL_W      = 5;    // holds 0..16
    localparam int unsigned DIV_W      = 16;   // divisor field
    localparam int unsigned THR_W      = 8;    // threshold codes
    localparam int unsigned FSZ_W      = 5;    // frame size minus one

    // ==========================================================
    // reset values
    // ==========================================================
    localparam logic [WORD_W-1:0] DATA_RESET = 32'h0000_0000;
    localparam logic [LVL_W-1:0]  LVL_EMPTY  = 5'h00;
    localparam logic [LVL_W-1:0]  LVL_FULL   = 5'h10;
    localparam logic [FSZ_W-1:0]  BIT_RESET  = 5'h00;
    localparam logic [DIV_W-2:0]  HALF_RESET = 15'h0000;

    // ==========================================================
    // shifter states
    // ==========================================================
    typedef enum logic [1:0] {
        S_IDLE,
        S_SHIFT,
        S_PUSH
    } sfc_state_t;

endpackage

//--- sfc_fifo_if.sv
// fifo connection between the shifter top and a fifo instance
interface sfc_fifo_if #(
    parameter int unsigned W  = 32,
    parameter int unsigned LW = 5
);
    logic          clear;
    logic          push_valid;
    logic          push_ready;
    logic [W-1:0]  push_data;
    logic          pop_valid;
    logic          pop_ready;
    logic [W-1:0]  pop_data;
    logic [LW-1:0] level;

    // the owner of the fifo drives readiness, validity and level
    modport store (
        input  clear, push_valid, push_data, pop_ready,
        output push_ready, pop_valid, pop_data, level
    );
    modport user (
        output clear, push_valid, push_data, pop_ready,
        input  push_ready, pop_valid, pop_data, level
    );
endinterface

//--- sfc_fifo.sv
// flip-flop fifo with valid/ready on both sides and synchronous clear
module sfc_fifo
    import sfc_pkg::*;
#(
    parameter int unsigned WIDTH = sfc_pkg::WORD_W,
    parameter int unsigned DEPTH = sfc_pkg::FIFO_DEPTH
) (
    input  wire logic i_ref_clk,
    input  wire logic i_rstn,
    sfc_fifo_if.store f
);
    import sfc_pkg::*;

    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [LVL_W-1:0] count;
    logic [PW-1:0]    next_wr_ptr;
    logic [PW-1:0]    next_rd_ptr;
    logic [LVL_W-1:0] next_count;
    logic             do_push;
    logic             do_pop;

    // ==========================================================
    // handshake and pointer update
    // ==========================================================
    assign f.push_ready = (count != LVL_W'(DEPTH));
    assign f.pop_valid  = (count != LVL_EMPTY);
    assign f.pop_data   = mem[rd_ptr];
    assign f.level      = count;

    // a push while full is simply not taken; the user flags it
    always_comb begin
        do_push     = f.push_valid && f.push_ready;
        do_pop      = f.pop_ready && f.pop_valid;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (f.clear) begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_count  = LVL_EMPTY;
        end else begin
            if (do_push) begin
                next_wr_ptr = (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
            end
            if (do_pop) begin
                next_rd_ptr = (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
            end
            if (do_push && !do_pop) begin
                next_count = count + 1'b1;
            end else if (do_pop && !do_push) begin
                next_count = count - 1'b1;
            end
        end
    end

    // pointers and occupancy; storage is flip-flops, not a macro
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= LVL_EMPTY;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    // storage write, no reset needed on data
    always_ff @(posedge i_ref_clk) begin
        if (do_push && !f.clear) begin
            mem[wr_ptr] <= f.push_data;
        end
    end

    fifo_bound_a: assert property (  // [RULE4]
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (count == LVL_W'(DEPTH) && f.push_valid && !f.pop_ready
            && !f.clear)
            |=> (count == LVL_W'(DEPTH)))
        else $error("fifo grew past its depth");
endmodule

//--- sfc_master.sv
// serial master: bit clock divider, shifter and both data fifos
// Overview of operation
// RULE1: bit clock at most half the core clock
// RULE2: bit clock toggles only during a transfer
// RULE3: bit rate is core clock over divisor; 0 stops; the code drops the divisor lsb, so 1 also stops
// RULE4: two flip-flop fifos, 16 by 32 bits
// RULE5: software right-aligns short transmit frames
// RULE6: received frames stored right-aligned, last bit lsb
// RULE7: one frame per entry, upper bits ignored
// RULE8: disable or reset empties both fifos
// RULE9: data port write pushes, shifter pops transmit
// RULE10: low-water while transmit level at or below threshold
// RULE11: threshold code n means n or fewer entries
// RULE12: write to full transmit fifo raises overflow
// RULE13: data port read pops, shifter pushes receive
// RULE14: high-water while receive level at least threshold+1
// RULE15: code n means n+1 or more entries
// RULE16: push to full receive fifo flags overrun, drops
// RULE17: read of empty receive fifo flags underflow
// RULE18: software programs everything, then select, then enable
// RULE19: overflowing word dropped; flag held until clear read
// RULE20: underflowing read returns all zeros
// RULE21: low-water clears itself once level exceeds threshold
module sfc_master
    import sfc_pkg::*;
(
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_rstn,
    input  wire logic                       i_enable,
    input  wire logic                       i_slave_select,
    input  wire logic [sfc_pkg::DIV_W-1:0]  i_clock_divisor,
    input  wire logic [sfc_pkg::THR_W-1:0]  i_tx_threshold_code,
    input  wire logic [sfc_pkg::THR_W-1:0]  i_rx_threshold_code,
    input  wire logic [sfc_pkg::FSZ_W-1:0]  i_frame_size_m1,
    input  wire logic                       i_sclk_idle,
    input  wire logic                       i_data_wr,
    input  wire logic [sfc_pkg::WORD_W-1:0] i_data_wdata,
    input  wire logic                       i_data_rd,
    input  wire logic                       i_tx_ovf_clr_rd,
    input  wire logic                       i_rx_ovr_clr_rd,
    input  wire logic                       i_rx_udf_clr_rd,
    input  wire logic                       i_rxd,
    output logic      [sfc_pkg::WORD_W-1:0] o_data_rdata,
    output logic                            o_data_rvalid,
    output logic                            o_tx_low_water,
    output logic                            o_tx_overflow,
    output logic                            o_rx_high_water,
    output logic                            o_rx_overrun,
    output logic                            o_rx_underflow,
    output logic      [sfc_pkg::LVL_W-1:0]  o_tx_level,
    output logic      [sfc_pkg::LVL_W-1:0]  o_rx_level,
    output logic                            o_busy,
    output logic                            o_sclk,
    output logic                            o_ss_n,
    output logic                            o_txd
);
    import sfc_pkg::*;

    sfc_fifo_if #(.W(WORD_W), .LW(LVL_W)) tx_if ();
    sfc_fifo_if #(.W(WORD_W), .LW(LVL_W)) rx_if ();

    // ==========================================================
    // fifos
    // ==========================================================
    // storage is flip-flops inside each fifo [RULE4]
    sfc_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .i_ref_clk (i_ref_clk),
        .i_rstn    (i_rstn),
        .f         (tx_if.store)
    );
    sfc_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .i_ref_clk (i_ref_clk),
        .i_rstn    (i_rstn),
        .f         (rx_if.store)
    );

    sfc_state_t        state;
    sfc_state_t        next_state;
    logic [DIV_W-2:0]  div_cnt;
    logic [DIV_W-2:0]  next_div_cnt;
    logic [DIV_W-2:0]  half;
    logic [DIV_W-2:0]  half_m1;
    logic              tick;
    logic              phase;
    logic              next_phase;
    logic [FSZ_W-1:0]  bits;
    logic [FSZ_W-1:0]  next_bits;
    logic [WORD_W-1:0] tx_sh;
    logic [WORD_W-1:0] next_tx_sh;
    logic [WORD_W-1:0] rx_sh;
    logic [WORD_W-1:0] next_rx_sh;
    logic              tx_pop;
    logic              rx_push;
    logic              next_sclk;
    logic              next_ss_n;
    logic              next_txd;

    // disabling clears both fifos; reset clears them inside [RULE8]
    assign tx_if.clear      = !i_enable;               // [RULE8]
    assign rx_if.clear      = !i_enable;               // [RULE8]
    assign tx_if.push_valid = i_data_wr;                // [RULE9]
    assign tx_if.push_data  = i_data_wdata;             // [RULE5]
    assign tx_if.pop_ready  = tx_pop;                   // [RULE9]
    assign rx_if.push_valid = rx_push;                  // [RULE13]
    assign rx_if.push_data  = rx_sh;                    // [RULE6]
    assign rx_if.pop_ready  = i_data_rd;                // [RULE13]

    // ==========================================================
    // bit clock divider and shifter
    // ==========================================================
    // the lsb of the divisor is dropped, so the half period is at
    // least one core cycle and the bit clock never beats clk/2
    assign half    = i_clock_divisor[DIV_W-1:1];        // [RULE1]
    assign half_m1 = half - 1'b1;
    assign tick    = (div_cnt == half_m1);              // [RULE3]

    always_comb begin
        next_state   = state;
        next_div_cnt = div_cnt;
        next_phase   = phase;
        next_bits    = bits;
        next_tx_sh   = tx_sh;
        next_rx_sh   = rx_sh;
        tx_pop       = 1'b0;
        rx_push      = 1'b0;
        unique case (state)
            S_IDLE: begin
                next_div_cnt = HALF_RESET;
                next_phase   = 1'b0;
                // start only once select and enable are both set
                // and a divisor of 2 or more is programmed [RULE18]
                if (i_enable && i_slave_select && half != HALF_RESET
                    && tx_if.pop_valid) begin               // [RULE3]
                    tx_pop     = 1'b1;                      // [RULE9]
                    next_tx_sh = tx_if.pop_data;
                    next_rx_sh = DATA_RESET;
                    next_bits  = i_frame_size_m1;
                    next_state = S_SHIFT;
                end
            end
            S_SHIFT: begin
                next_div_cnt = tick ? HALF_RESET : div_cnt + 1'b1;
                if (tick) begin
                    next_phase = !phase;
                    if (!phase) begin
                        // leading edge samples, lsb end fills last
                        next_rx_sh = {rx_sh[WORD_W-2:0], i_rxd}; // [RULE6]
                    end else if (bits == BIT_RESET) begin
                        next_state = S_PUSH;
                    end else begin
                        next_bits = bits - 1'b1;
                    end
                end
            end
            S_PUSH: begin
                // a full receive fifo refuses this and the frame is lost
                rx_push    = 1'b1;                          // [RULE13]
                next_state = S_IDLE;
            end
        endcase
        if (!i_enable) begin
            next_state = S_IDLE;
            next_phase = 1'b0;
        end
        // sclk runs only inside a frame, idle level otherwise [RULE2]
        next_sclk = (next_state == S_SHIFT) ? (i_sclk_idle ^ next_phase)
                                            : i_sclk_idle;
        next_ss_n = (next_state == S_IDLE);
        // msb first from the frame's top bit; bits above ignored
        next_txd  = next_tx_sh[next_bits];                  // [RULE7]
    end

    // shifter and pin registers
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state   <= S_IDLE;
            div_cnt <= HALF_RESET;
            phase   <= 1'b0;
            bits    <= BIT_RESET;
            tx_sh   <= DATA_RESET;
            rx_sh   <= DATA_RESET;
            o_sclk  <= 1'b0;
            o_ss_n  <= 1'b1;
            o_txd   <= 1'b0;
        end else begin
            state   <= next_state;
            div_cnt <= next_div_cnt;
            phase   <= next_phase;
            bits    <= next_bits;
            tx_sh   <= next_tx_sh;
            rx_sh   <= next_rx_sh;
            o_sclk  <= next_sclk;
            o_ss_n  <= next_ss_n;
            o_txd   <= next_txd;
        end
    end

    // ==========================================================
    // data port, flags and levels
    // ==========================================================
    logic [WORD_W-1:0] next_rdata;
    logic              next_tx_ovf;
    logic              next_rx_ovr;
    logic              next_rx_udf;
    logic              next_low;
    logic              next_high;

    // sticky flags: a new event in the clearing cycle wins
    always_comb begin
        next_rdata = o_data_rdata;
        next_rx_udf = o_rx_underflow && !i_rx_udf_clr_rd;
        if (i_data_rd) begin
            if (rx_if.pop_valid) begin
                next_rdata = rx_if.pop_data;
            end else begin
                next_rdata  = DATA_RESET;                   // [RULE20]
                next_rx_udf = 1'b1;                         // [RULE17]
            end
        end
        // the refused word is dropped by the fifo itself [RULE19]
        next_tx_ovf = (o_tx_overflow && !i_tx_ovf_clr_rd)   // [RULE19]
                    || (i_data_wr && !tx_if.push_ready      // [RULE12]
                        && i_enable);
        next_rx_ovr = (o_rx_overrun && !i_rx_ovr_clr_rd)
                    || (rx_push && !rx_if.push_ready && i_enable); // [RULE16]
        // level compares; low-water falls on its own above threshold
        next_low  = ({3'b000, tx_if.level}                  // [RULE10]
                    <= i_tx_threshold_code);        // [RULE11] [RULE21]
        next_high = ({4'b0000, rx_if.level}                 // [RULE14]
                    >= ({1'b0, i_rx_threshold_code} + 9'h001)); // [RULE15]
    end

    // flag and data registers; flags trail the fifo level by one cycle
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_data_rdata    <= DATA_RESET;
            o_data_rvalid   <= 1'b0;
            o_tx_low_water  <= 1'b0;
            o_tx_overflow   <= 1'b0;
            o_rx_high_water <= 1'b0;
            o_rx_overrun    <= 1'b0;
            o_rx_underflow  <= 1'b0;
            o_tx_level      <= LVL_EMPTY;
            o_rx_level      <= LVL_EMPTY;
            o_busy          <= 1'b0;
        end else begin
            o_data_rdata    <= next_rdata;
            o_data_rvalid   <= i_data_rd;
            o_tx_low_water  <= next_low;
            o_tx_overflow   <= next_tx_ovf;
            o_rx_high_water <= next_high;
            o_rx_overrun    <= next_rx_ovr;
            o_rx_underflow  <= next_rx_udf;
            o_tx_level      <= tx_if.level;
            o_rx_level      <= rx_if.level;
            o_busy          <= (next_state != S_IDLE);
        end
    end

    // ==========================================================
    // checks
    // ==========================================================
    sclk_idle_a: assert property (  // [RULE2]
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (state == S_IDLE && $past(state) == S_IDLE)
            |=> (o_sclk == $past(i_sclk_idle)))
        else $error("bit clock moved outside a transfer");

    sclk_rate_a: assert property (  // [RULE1] [RULE3]
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (state == S_SHIFT && next_state == S_SHIFT && phase != next_phase)
            |-> (div_cnt == half_m1 && half != HALF_RESET))
        else $error("bit clock edge off the divisor count");

    div_zero_a: assert property (  // [RULE3]
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (state == S_IDLE && half == HALF_RESET) |=> (state == S_IDLE))
        else $error("transfer started with divisor zero");

    disable_clear_a: assert property (  // [RULE8]
        @(posedge i_ref_clk) disable iff (!i_rstn)
        !i_enable |=> (tx_if.level == LVL_EMPTY && rx_if.level == LVL_EMPTY))
        else $error("fifos not emptied on disable");

    tx_overflow_a: assert property (  // [RULE12]
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_data_wr && tx_if.level == LVL_FULL && i_enable && !tx_pop)
            |=> (o_tx_overflow && tx_if.level == LVL_FULL))
        else $error("overflow not flagged or word taken");

    ovf_hold_a: assert property (  // [RULE19]
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (o_tx_overflow && !i_tx_ovf_clr_rd) |=> o_tx_overflow)
        else $error("overflow flag fell without a clear read");

    underflow_zero_a: assert property (  // [RULE17] [RULE20]
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_data_rd && rx_if.level == LVL_EMPTY)
            |=> (o_data_rdata == DATA_RESET && o_rx_underflow))
        else $error("empty read not zero or not flagged");

    low_water_a: assert property (  // [RULE10] [RULE21]
        @(posedge i_ref_clk) disable iff (!i_rstn)
        1'b1 |=> (o_tx_low_water == ({3'b000, $past(tx_if.level)}
                  <= $past(i_tx_threshold_code))))
        else $error("low-water flag wrong for level");

    high_water_a: assert property (  // [RULE14] [RULE15]
        @(posedge i_ref_clk) disable iff (!i_rstn)
        1'b1 |=> (o_rx_high_water == ({4'b0000, $past(rx_if.level)}
                  > {1'b0, $past(i_rx_threshold_code)})))
        else $error("high-water flag wrong for level");

    overrun_a: assert property (  // [RULE16]
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (rx_push && rx_if.level == LVL_FULL && !i_data_rd && i_enable)
            |=> (o_rx_overrun && rx_if.level == LVL_FULL))
        else $error("overrun not flagged or frame kept");
endmodule

//--- sfc_flash_model.sv
// behavioural serial flash: answers a fixed word, records what it hears
module sfc_flash_model #(
    parameter logic [31:0] RESP = 32'ha5c3_96e1
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_sclk,
    input  wire logic        i_ss_n,
    input  wire logic        i_txd,
    input  wire logic [4:0]  i_fsz,
    input  wire logic        i_idle,
    output logic             o_rxd,
    output logic      [31:0] o_got
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       ps;
    logic       pss;
    logic [4:0] idx;
    // ==========================================================
    // slave side
    // ==========================================================
    initial o_rxd = 1'b0;
    // edges are seen one core cycle late, so rxd moves well after sampling
    always @(posedge i_ref_clk) begin
        ps  <= i_sclk;
        pss <= i_ss_n;
        if (i_ss_n) begin
            o_rxd <= ~o_rxd; // deselected: line must not hold a stale bit
        end else if (pss) begin
            o_rxd <= RESP[i_fsz]; // msb ready before the first edge when the divisor is 4 or more
            idx   <= i_fsz - 5'h01;
        end else if (ps == i_idle && i_sclk != i_idle) begin
            o_got <= {o_got[30:0], i_txd}; // leading edge capture
        end else if (ps != i_idle && i_sclk == i_idle) begin
            o_rxd <= RESP[idx]; // next bit after trailing edge
            idx   <= idx - 5'h01;
        end
    end
endmodule

//--- tb_sfc_master.sv
// self-checking bench for the serial master against a flash model
module tb_sfc_master;
    timeunit 1ns;
    timeprecision 1ns;
    import sfc_pkg::*;
    localparam logic [31:0] RESP = 32'ha5c3_96e1;
    logic              clk  = 1'b0;
    logic              rstn = 1'b0;
    logic              en   = 1'b0;
    logic              sel  = 1'b0;
    logic              idle = 1'b0;
    logic              wr_s = 1'b0;
    logic              rd_s = 1'b0;
    logic [2:0]        clr  = 3'h0;
    logic [15:0]       div  = 16'h0000;
    logic [7:0]        tc   = 8'h00;
    logic [7:0]        rc   = 8'h00;
    logic [4:0]        fsz  = 5'h07;
    logic [31:0]       wd   = 32'h0000_0000;
    logic [31:0]       rdat;
    logic [31:0]       got;
    logic              rxd;
    logic              rval;
    logic              lw;
    logic              ovf;
    logic              hw;
    logic              ovr;
    logic              udf;
    logic              busy;
    logic              sclk;
    logic              ss_n;
    logic              txd;
    logic [LVL_W-1:0]  txl;
    logic [LVL_W-1:0]  rxl;
    int                fails   = 0;
    int                n_tests = 0;
    sfc_master u_dut (.i_ref_clk(clk), .i_rstn(rstn), .i_enable(en),
        .i_slave_select(sel), .i_clock_divisor(div),
        .i_tx_threshold_code(tc), .i_rx_threshold_code(rc),
        .i_frame_size_m1(fsz), .i_sclk_idle(idle), .i_data_wr(wr_s),
        .i_data_wdata(wd), .i_data_rd(rd_s), .i_tx_ovf_clr_rd(clr[2]),
        .i_rx_ovr_clr_rd(clr[1]), .i_rx_udf_clr_rd(clr[0]), .i_rxd(rxd),
        .o_data_rdata(rdat), .o_data_rvalid(rval), .o_tx_low_water(lw),
        .o_tx_overflow(ovf), .o_rx_high_water(hw), .o_rx_overrun(ovr),
        .o_rx_underflow(udf), .o_tx_level(txl), .o_rx_level(rxl),
        .o_busy(busy), .o_sclk(sclk), .o_ss_n(ss_n), .o_txd(txd));
    sfc_flash_model #(.RESP(RESP)) u_flash (.i_ref_clk(clk), .i_sclk(sclk),
        .i_ss_n(ss_n), .i_txd(txd), .i_fsz(fsz), .i_idle(idle),
        .o_rxd(rxd), .o_got(got));
    always #10 clk = ~clk;
    // ==========================================================
    // helpers
    // ==========================================================
    task automatic clk_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("ERROR %0t word %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_bit(input logic g, input logic e);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("ERROR %0t flag %b expected %b", $time, g, e);
        end
    endtask
    // one pulse on the data port, then let the levels settle
    task automatic wr(input logic [31:0] d);
        @(posedge clk);
        wr_s <= 1'b1;
        wd   <= d;
        @(posedge clk);
        wr_s <= 1'b0;
        clk_n(3);
    endtask
    task automatic rd(output logic [31:0] d);
        @(posedge clk);
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        for (int i = 0; i < 3 && rval !== 1'b1; i++) clk_n(1);
        chk_bit(rval, 1'b1);
        d = rdat;
        clk_n(3);
    endtask
    task automatic clear(input logic [2:0] w);
        @(posedge clk);
        clr <= w;
        @(posedge clk);
        clr <= 3'h0;
        clk_n(3);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 4000 && !(txl === 5'h00 && busy === 1'b0); i++)
            clk_n(1);
        clk_n(6);
    endtask
    task automatic finish_test();
        if (fails == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ==========================================================
    // scenarios
    // ==========================================================
    task automatic t_reset();
        chk_word(32'(txl), 32'h0000_0000);
        chk_word(32'(rxl), 32'h0000_0000);
        chk_bit(lw, 1'b1);
        chk_bit(sclk, idle);
        chk_bit(ss_n, 1'b1);
        chk_bit(ovf | ovr | udf, 1'b0);
    endtask
    // divisor 0 keeps the shifter quiet while the tx fifo fills
    task automatic t_tx_fill();
        @(posedge clk);
        sel <= 1'b1; // select before enable
        @(posedge clk);
        en <= 1'b1;
        for (int k = 0; k <= 16; k++) begin
            for (int c = 0; c < 16; c++) begin
                @(posedge clk);
                tc <= 8'(c);
                clk_n(2);
                chk_bit(lw, 1'(k <= c));
            end
            chk_word(32'(txl), 32'(k));
            if (k < 16) wr(32'hdead_be00 | 32'(k));
        end
        wr(32'h0000_00ff);
        chk_bit(ovf, 1'b1);
        chk_word(32'(txl), 32'h0000_0010);
        chk_bit(busy, 1'b0);
        chk_bit(sclk, idle);
        clear(3'h4);
        chk_bit(ovf, 1'b0);
    endtask
    task automatic t_rx();
        logic [31:0] d;
        @(posedge clk);
        div <= 16'h0004;
        wait_idle();
        chk_word({24'h00_0000, got[7:0]}, 32'h0000_000f);
        chk_word(32'(rxl), 32'h0000_0010);
        chk_bit(ovr, 1'b0);
        wr(32'h0000_0033);
        wait_idle();
        chk_word({24'h00_0000, got[7:0]}, 32'h0000_0033);
        chk_bit(ovr, 1'b1);
        clear(3'h2);
        chk_bit(ovr, 1'b0);
        for (int k = 16; k >= 0; k--) begin
            for (int c = 0; c < 16; c++) begin
                @(posedge clk);
                rc <= 8'(c);
                clk_n(2);
                chk_bit(hw, 1'(k >= c + 1));
            end
            if (k > 0) begin
                rd(d);
                chk_word(d, {24'h00_0000, RESP[7:0]});
            end
        end
        rd(d);
        chk_word(d, 32'h0000_0000);
        chk_bit(udf, 1'b1);
        clear(3'h1);
        chk_bit(udf, 1'b0);
    endtask
    // each half period must last divisor/2 core cycles
    task automatic t_clock();
        int t;
        @(posedge clk);
        div  <= 16'h0000;
        idle <= 1'b1;
        fsz  <= 5'h03;
        wr(32'h0000_0005);
        @(posedge clk);
        div <= 16'h0006;
        clk_n(1);
        for (t = 0; t < 100 && sclk === idle; t++) clk_n(1);
        for (t = 0; t < 100 && sclk !== idle; t++) clk_n(1);
        chk_word(32'(t), 32'h0000_0003);
        for (t = 0; t < 100 && sclk === idle; t++) clk_n(1);
        chk_word(32'(t), 32'h0000_0003);
        wait_idle();
        chk_bit(sclk, 1'b1);
        chk_word({28'h000_0000, got[3:0]}, 32'h0000_0005);
        chk_word(32'(rxl), 32'h0000_0001);
        @(posedge clk);
        en <= 1'b0;
        clk_n(4);
        chk_word(32'(rxl), 32'h0000_0000);
        @(posedge clk);
        en  <= 1'b1;
        div <= 16'h0000;
        wr(32'h0000_0001);
        chk_word(32'(txl), 32'h0000_0001);
        // reset in mid-run must empty a loaded fifo
        @(posedge clk);
        rstn <= 1'b0;
        clk_n(2);
        @(posedge clk);
        rstn <= 1'b1;
        clk_n(2);
        chk_word(32'(txl), 32'h0000_0000);
        chk_bit(lw, 1'b1);
        chk_bit(ss_n, 1'b1);
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        fails++;
        finish_test();
    end
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        clk_n(2);
        t_reset();
        t_tx_fill();
        t_rx();
        t_clock();
        finish_test();
    end
endmodule
